// ===== icfr_pkg.sv
// Constants, field positions and carrier types of the interrupt control and flag registers.
// Assumes a 20 MHz core clock, an APB master with 8-bit addresses and a synchronous reset.
`default_nettype none
package icfr_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL2 = 8'h00;
	localparam logic [7:0] OFS_CTRL3 = 8'h04;
	localparam logic [7:0] OFS_REQ1 = 8'h08;
	localparam logic [7:0] OFS_REQ2 = 8'h0C;
	localparam logic [7:0] OFS_CORE = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// Reset values
	localparam logic [7:0] RST_CTRL2 = 8'hE5;
	localparam logic [7:0] RST_CTRL3 = 8'hC0;
	localparam logic [7:0] RST_REQ = 8'h00;
	localparam logic [7:0] RST_CORE = 8'h00;

	// Implemented and software-writable bits
	localparam logic [7:0] CTRL2_MASK = 8'hE5;
	localparam logic [7:0] CTRL3_MASK = 8'hDB;
	localparam logic [7:0] REQ1_SW_MASK = 8'hCF;
	localparam logic [7:0] REQ2_MASK = 8'h5F;
	localparam logic [7:0] CORE_MASK = 8'hC1;

	// Field positions
	localparam int C2_PULLUP_DIS = 7;
	localparam int C2_EDGE0 = 6;
	localparam int C2_EDGE1 = 5;
	localparam int C2_T0_PRIO = 2;
	localparam int C2_PC_PRIO = 0;
	localparam int C3_PRIO2 = 7;
	localparam int C3_PRIO1 = 6;
	localparam int C3_EN2 = 4;
	localparam int C3_EN1 = 3;
	localparam int C3_FLAG2 = 1;
	localparam int C3_FLAG1 = 0;
	localparam int R1_RX_FULL = 5;
	localparam int R1_TX_EMPTY = 4;
	localparam int CORE_GLOBAL_IRQ_ENABLE = 7;
	localparam int CORE_PERIPHERAL_IRQ_ENABLE = 6;
	localparam int CORE_PRIORITY_LEVELS_ENABLE = 0;

	// Vector addresses
	localparam logic [23:0] VEC_HIGH = 24'h000008;
	localparam logic [23:0] VEC_LOW = 24'h000018;

	typedef enum logic [1:0] {
		ICFR_CC_CAPTURE = 2'b00,
		ICFR_CC_COMPARE = 2'b01,
		ICFR_CC_PWM = 2'b10,
		ICFR_CC_OFF = 2'b11
	} icfr_ccmode_t;

	// One-cycle event pulses from the peripherals
	typedef struct packed {
		logic parallel_access;
		logic conversion_done;
		logic rx_load;
		logic rx_buffer_read;
		logic tx_drain;
		logic tx_buffer_write;
		logic sync_serial_done;
		logic capcomp_one_capture;
		logic capcomp_one_match;
		logic timer2_match;
		logic timer1_ovf;
		logic nvm_write_done;
		logic bus_collision;
		logic low_voltage;
		logic timer3_ovf;
		logic enhanced_capture;
		logic enhanced_match;
	} icfr_events_t;

	// Enables and priorities held outside this block
	typedef struct packed {
		logic [7:0] req_one_enable;
		logic [7:0] req_two_enable;
		logic [7:0] req_one_priority;
		logic [7:0] req_two_priority;
		logic timer0_ovf_pending;
		logic port_change_pending;
	} icfr_enables_t;

	typedef struct packed {
		logic [7:0] ctrl2;
		logic [7:0] ctrl3;
		logic [7:0] req_one;
		logic [7:0] req_two;
		logic [7:0] core;
		logic primed;
		logic [2:0] pin_prev;
		logic [1:0] cmp_prev;
		logic ext_irq0_event;
		logic [7:0] pullup_enable;
		logic irq_request;
		logic [23:0] irq_vector;
		logic [31:0] prdata;
		logic pslverr;
	} icfr_state_t;

	localparam icfr_state_t RST_STATE = '{ctrl2: RST_CTRL2, ctrl3: RST_CTRL3, req_one: RST_REQ,
		req_two: RST_REQ, core: RST_CORE, irq_vector: VEC_HIGH, default: '0};
endpackage : icfr_pkg
`default_nettype wire

// ===== icfr_flags.sv
// Interrupt control registers two and three, peripheral request registers one and two, vectoring.
// Assumes an APB master, single-cycle event pulses and pins synchronous to clk.
//
// Overview of operation
// [RULE1] Pull-up disable bit forces all pull-ups off
// [RULE2] Edge select zero: falling, one: rising
// [RULE3] Same edge select for external interrupt one
// [RULE4] Timer zero overflow priority bit picks level
// [RULE5] Port change priority bit picks level
// [RULE6] Unimplemented bits always read zero
// [RULE7] Control three bits 7,6 set priorities
// [RULE8] Control three bits 4,3 enable interrupts
// [RULE9] External flags set, held until software clears
// [RULE10] Flags set regardless of any enable
// [RULE11] Software clears flags before enabling, after servicing
// [RULE12] Parallel port flag; absent variant reads zero
// [RULE13] Conversion done flag held until cleared
// [RULE14] Receive flag read-only, cleared by buffer read
// [RULE15] Transmit flag read-only, cleared by buffer write
// [RULE16] Sync serial done flag held until cleared
// [RULE17] Capture/compare flag by mode, unused in PWM
// [RULE18] Timer two match, timer one overflow flags
// [RULE19] Comparator change flag; absent variant reads zero
// [RULE20] Memory write done and collision flags held
// [RULE21] Low voltage and timer three flags held
// [RULE22] Enhanced capture/compare flag, variant dependent
// [RULE23] High and low priority fixed vectors
// [RULE24] Priority bits ignored while priority disabled
// [RULE25] Peripheral enable needed in single-level mode
// [RULE26] Hardware set beats software clear
//
// Implementation choices: the APB register port and the register addresses.
`default_nettype none
module icfr_flags #(
	parameter bit HAS_PARALLEL_PORT = 1'b1,
	parameter bit HAS_COMPARATOR = 1'b1,
	parameter bit HAS_ENHANCED = 1'b1,
	parameter bit EXT_IRQ2_RISING = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Peripheral events and pins
	input wire icfr_pkg::icfr_events_t events,
	input wire icfr_pkg::icfr_ccmode_t capcomp_one_mode,
	input wire icfr_pkg::icfr_ccmode_t enhanced_mode,
	input wire logic [2:0] ext_irq_pin,
	input wire logic [1:0] comparator_out,
	input wire logic [7:0] portb_latch,
	// Enables held elsewhere
	input wire icfr_pkg::icfr_enables_t enables,
	// To port logic and core
	output logic [7:0] portb_pullup_enable,
	output logic ext_irq0_event,
	output logic irq_request,
	output logic [23:0] irq_vector
);
	import icfr_pkg::*;

	icfr_state_t r;
	icfr_state_t next_r;

	logic setup;
	logic wr;
	logic wr_ctrl2;
	logic wr_ctrl3;
	logic wr_req1;
	logic wr_req2;
	logic wr_core;
	logic [2:0] rise;
	logic [2:0] fall;
	logic edge0;
	logic edge1;
	logic edge2;
	logic capcomp_set;
	logic enhanced_set;
	logic cmp_change;
	logic [7:0] set_one;
	logic [7:0] set_two;
	logic [7:0] avail_one;
	logic [7:0] avail_two;
	logic [7:0] per_one;
	logic [7:0] per_two;
	logic ext1_pend;
	logic ext2_pend;
	logic hi_pend;
	logic lo_pend;
	logic single_pend;
	logic global_irq_enable;
	logic peripheral_irq_enable;
	logic priority_levels_enable;

	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign wr_ctrl2 = wr & (paddr == OFS_CTRL2);
	assign wr_ctrl3 = wr & (paddr == OFS_CTRL3);
	assign wr_req1 = wr & (paddr == OFS_REQ1);
	assign wr_req2 = wr & (paddr == OFS_REQ2);
	assign wr_core = wr & (paddr == OFS_CORE);
	assign global_irq_enable = r.core[CORE_GLOBAL_IRQ_ENABLE];
	assign peripheral_irq_enable = r.core[CORE_PERIPHERAL_IRQ_ENABLE];
	assign priority_levels_enable = r.core[CORE_PRIORITY_LEVELS_ENABLE];

	// Priming stops a pin that is high at reset from faking an edge
	assign rise = ext_irq_pin & ~r.pin_prev & {3{r.primed}};
	assign fall = ~ext_irq_pin & r.pin_prev & {3{r.primed}};
	assign edge0 = r.ctrl2[C2_EDGE0] ? rise[0] : fall[0]; // RULE2
	assign edge1 = r.ctrl2[C2_EDGE1] ? rise[1] : fall[1]; // RULE3
	assign edge2 = EXT_IRQ2_RISING ? rise[2] : fall[2];
	assign cmp_change = r.primed & (|(comparator_out ^ r.cmp_prev));

	// PWM and off modes never raise the capture/compare flags
	assign capcomp_set = ((capcomp_one_mode == ICFR_CC_CAPTURE) & events.capcomp_one_capture)
		| ((capcomp_one_mode == ICFR_CC_COMPARE) & events.capcomp_one_match); // RULE17
	assign enhanced_set = ((enhanced_mode == ICFR_CC_CAPTURE) & events.enhanced_capture)
		| ((enhanced_mode == ICFR_CC_COMPARE) & events.enhanced_match); // RULE22

	assign set_one = {events.parallel_access, events.conversion_done, events.rx_load, events.tx_drain,
		events.sync_serial_done, capcomp_set, events.timer2_match, events.timer1_ovf}; // RULE10
	assign set_two = {1'b0, cmp_change, 1'b0, events.nvm_write_done, events.bus_collision,
		events.low_voltage, events.timer3_ovf, enhanced_set}; // RULE10
	assign avail_one = {HAS_PARALLEL_PORT, 7'h7F}; // RULE12
	assign avail_two = REQ2_MASK & {1'b1, HAS_COMPARATOR, 5'h1F, HAS_ENHANCED}; // RULE19 RULE22

	// Pending sources for vectoring
	assign ext1_pend = r.ctrl3[C3_FLAG1] & r.ctrl3[C3_EN1]; // RULE8
	assign ext2_pend = r.ctrl3[C3_FLAG2] & r.ctrl3[C3_EN2]; // RULE8
	assign per_one = r.req_one & enables.req_one_enable;
	assign per_two = r.req_two & enables.req_two_enable;
	assign hi_pend = (ext2_pend & r.ctrl3[C3_PRIO2]) | (ext1_pend & r.ctrl3[C3_PRIO1]) // RULE7
		| (enables.timer0_ovf_pending & r.ctrl2[C2_T0_PRIO]) // RULE4
		| (enables.port_change_pending & r.ctrl2[C2_PC_PRIO]) // RULE5
		| (|(per_one & enables.req_one_priority)) | (|(per_two & enables.req_two_priority));
	assign lo_pend = (ext2_pend & ~r.ctrl3[C3_PRIO2]) | (ext1_pend & ~r.ctrl3[C3_PRIO1])
		| (enables.timer0_ovf_pending & ~r.ctrl2[C2_T0_PRIO])
		| (enables.port_change_pending & ~r.ctrl2[C2_PC_PRIO])
		| (|(per_one & ~enables.req_one_priority)) | (|(per_two & ~enables.req_two_priority));
	// Single level: priority bits play no part, peripherals need their group enable
	assign single_pend = ext2_pend | ext1_pend | enables.timer0_ovf_pending | enables.port_change_pending
		| (peripheral_irq_enable & (|per_one | |per_two)); // RULE24 RULE25

	always_comb begin
		next_r = r;
		next_r.primed = 1'b1;
		next_r.pin_prev = ext_irq_pin;
		next_r.cmp_prev = comparator_out;
		next_r.ext_irq0_event = edge0; // RULE2
		next_r.pullup_enable = r.ctrl2[C2_PULLUP_DIS] ? 8'h00 : portb_latch; // RULE1

		// Control registers; unimplemented bits never stored
		if (wr_ctrl2) begin
			next_r.ctrl2 = pwdata[7:0] & CTRL2_MASK; // RULE6
		end
		if (wr_core) begin
			next_r.core = pwdata[7:0] & CORE_MASK;
		end
		if (wr_ctrl3) begin
			next_r.ctrl3 = pwdata[7:0] & CTRL3_MASK; // RULE6 RULE7 RULE8
		end
		// Edge sets OR in after the write so a same-cycle clear loses
		next_r.ctrl3[C3_FLAG1] = next_r.ctrl3[C3_FLAG1] | edge1; // RULE9 RULE26
		next_r.ctrl3[C3_FLAG2] = next_r.ctrl3[C3_FLAG2] | edge2; // RULE9 RULE26

		// Request register one; buffer flags ignore software writes
		if (wr_req1) begin
			next_r.req_one = (pwdata[7:0] & REQ1_SW_MASK) | (r.req_one & ~REQ1_SW_MASK); // RULE14 RULE15
		end
		next_r.req_one[R1_RX_FULL] = r.req_one[R1_RX_FULL] & ~events.rx_buffer_read; // RULE14
		next_r.req_one[R1_TX_EMPTY] = r.req_one[R1_TX_EMPTY] & ~events.tx_buffer_write; // RULE15
		next_r.req_one = (next_r.req_one | set_one) & avail_one; // RULE12 RULE13 RULE16 RULE18 RULE26

		// Request register two
		if (wr_req2) begin
			next_r.req_two = pwdata[7:0];
		end
		next_r.req_two = (next_r.req_two | set_two) & avail_two; // RULE19 RULE20 RULE21 RULE22 RULE26

		// Vectoring; high level wins over low
		if (priority_levels_enable) begin
			next_r.irq_request = (global_irq_enable & hi_pend) | (peripheral_irq_enable & lo_pend);
			next_r.irq_vector = (global_irq_enable & hi_pend) ? VEC_HIGH : VEC_LOW; // RULE23
		end else begin
			next_r.irq_request = global_irq_enable & single_pend; // RULE25
			next_r.irq_vector = VEC_HIGH; // RULE24
		end

		// Read data captured in the setup phase, shown in the access phase
		if (setup) begin
			next_r.pslverr = 1'b0;
			unique case (paddr)
				OFS_CTRL2: next_r.prdata = {24'h000000, r.ctrl2}; // RULE6
				OFS_CTRL3: next_r.prdata = {24'h000000, r.ctrl3}; // RULE6
				OFS_REQ1: next_r.prdata = {24'h000000, r.req_one};
				OFS_REQ2: next_r.prdata = {24'h000000, r.req_two}; // RULE6
				OFS_CORE: next_r.prdata = {24'h000000, r.core};
				OFS_STATUS: next_r.prdata = {30'h00000000, r.irq_vector == VEC_LOW, r.irq_request};
				default: begin
					next_r.prdata = 32'h00000000;
					next_r.pslverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r <= RST_STATE;
		end else begin
			r <= next_r;
		end
	end

	// Zero wait states keep the bus simple; no access here needs more time
	assign pready = 1'b1;
	assign prdata = r.prdata;
	assign pslverr = r.pslverr;
	assign portb_pullup_enable = r.pullup_enable;
	assign ext_irq0_event = r.ext_irq0_event;
	assign irq_request = r.irq_request;
	assign irq_vector = r.irq_vector;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence seq_int1_rise;
		r.primed && r.ctrl2[C2_EDGE1] && !r.pin_prev[1] && ext_irq_pin[1];
	endsequence

	sequence seq_ctrl2_read;
		psel && penable && !pwrite && paddr == OFS_CTRL2;
	endsequence

	sequence seq_ctrl3_read;
		psel && penable && !pwrite && paddr == OFS_CTRL3;
	endsequence

	sequence seq_req2_read;
		psel && penable && !pwrite && paddr == OFS_REQ2;
	endsequence

	sequence seq_low_only;
		priority_levels_enable && peripheral_irq_enable && lo_pend && !(global_irq_enable && hi_pend);
	endsequence

	pullup_off_a: assert property (r.ctrl2[C2_PULLUP_DIS] |=> portb_pullup_enable == 8'h00) // RULE1
		else $error("pull-ups not disabled");
	int0_fall_a: assert property (r.primed && !r.ctrl2[C2_EDGE0] && r.pin_prev[0] && !ext_irq_pin[0] // RULE2
		|=> ext_irq0_event) else $error("falling edge on irq0 missed");
	int1_rise_a: assert property (seq_int1_rise |=> r.ctrl3[C3_FLAG1]) // RULE3
		else $error("rising edge on irq1 missed");
	t0_high_vec_a: assert property (priority_levels_enable && global_irq_enable && enables.timer0_ovf_pending // RULE4
		&& r.ctrl2[C2_T0_PRIO] |=> irq_request && irq_vector == VEC_HIGH) else $error("timer0 not high");
	ctrl2_zero_a: assert property (seq_ctrl2_read |-> prdata[4:3] == 2'b00 && !prdata[1] // RULE6
		&& prdata[31:8] == 24'h000000) else $error("reserved bits not zero");
	flag_hold_a: assert property (r.ctrl3[C3_FLAG1] && !wr_ctrl3 |=> r.ctrl3[C3_FLAG1]) // RULE9
		else $error("irq1 flag dropped");
	rx_clear_a: assert property (events.rx_buffer_read && !events.rx_load |=> !r.req_one[R1_RX_FULL]) // RULE14
		else $error("rx flag not cleared by read");
	tx_clear_a: assert property (events.tx_buffer_write && !events.tx_drain |=> !r.req_one[R1_TX_EMPTY]) // RULE15
		else $error("tx flag not cleared by write");
	set_wins_a: assert property (wr_req1 && !pwdata[0] && events.timer1_ovf |=> r.req_one[0]) // RULE26
		else $error("set lost to clear");
	t1_poll_a: assert property (events.timer1_ovf |=> r.req_one[0]) // RULE10
		else $error("timer1 flag not set");
	single_vec_a: assert property (!priority_levels_enable |=> irq_vector == VEC_HIGH) // RULE24
		else $error("single level not at high vector");
	periph_gate_a: assert property (!priority_levels_enable && !peripheral_irq_enable && !ext1_pend // RULE25
		&& !ext2_pend && !enables.timer0_ovf_pending && !enables.port_change_pending |=> !irq_request)
		else $error("peripheral request without group enable");
	int0_rise_a: assert property (r.primed && r.ctrl2[C2_EDGE0] && !r.pin_prev[0] && ext_irq_pin[0] // RULE2
		|=> ext_irq0_event) else $error("rising edge on irq0 missed");
	pullup_follow_a: assert property (!r.ctrl2[C2_PULLUP_DIS] // RULE1
		|=> portb_pullup_enable == $past(portb_latch)) else $error("pull-ups not following latch");
	port_prio_a: assert property (priority_levels_enable && global_irq_enable && enables.port_change_pending // RULE5
		&& r.ctrl2[C2_PC_PRIO] |=> irq_request && irq_vector == VEC_HIGH) else $error("port change not high");
	ctrl3_zero_a: assert property (seq_ctrl3_read |-> !prdata[5] && !prdata[2]) // RULE6
		else $error("control three reserved bits not zero");
	req2_zero_a: assert property (seq_req2_read |-> !prdata[7] && !prdata[5]) // RULE6
		else $error("request two reserved bits not zero");
	flag2_set_a: assert property (r.primed && EXT_IRQ2_RISING && !r.pin_prev[2] && ext_irq_pin[2] // RULE9
		|=> r.ctrl3[C3_FLAG2]) else $error("irq2 flag not set");
	parallel_set_a: assert property (events.parallel_access |=> r.req_one[7] == HAS_PARALLEL_PORT) // RULE12
		else $error("parallel port flag wrong");
	conv_set_a: assert property (events.conversion_done |=> r.req_one[6]) // RULE13
		else $error("conversion flag not set");
	rx_set_a: assert property (events.rx_load |=> r.req_one[R1_RX_FULL]) // RULE14
		else $error("rx flag not set");
	rx_readonly_a: assert property (r.req_one[R1_RX_FULL] && wr_req1 && !events.rx_buffer_read // RULE14
		|=> r.req_one[R1_RX_FULL]) else $error("rx flag cleared by write");
	tx_set_a: assert property (events.tx_drain |=> r.req_one[R1_TX_EMPTY]) // RULE15
		else $error("tx flag not set");
	sync_set_a: assert property (events.sync_serial_done |=> r.req_one[3]) // RULE16
		else $error("sync serial flag not set");
	cc_capture_a: assert property (capcomp_one_mode == ICFR_CC_CAPTURE && events.capcomp_one_capture // RULE17
		|=> r.req_one[2]) else $error("capture flag not set");
	cc_pwm_a: assert property (capcomp_one_mode == ICFR_CC_PWM && !wr_req1 && !r.req_one[2] // RULE17
		|=> !r.req_one[2]) else $error("capture flag set in pwm mode");
	t2_match_a: assert property (events.timer2_match |=> r.req_one[1]) // RULE18
		else $error("timer2 flag not set");
	t1_hold_a: assert property (r.req_one[0] && !wr_req1 |=> r.req_one[0]) // RULE18
		else $error("timer1 flag dropped");
	cmp_set_a: assert property (r.primed && comparator_out != r.cmp_prev // RULE19
		|=> r.req_two[6] == HAS_COMPARATOR) else $error("comparator flag wrong");
	nvm_set_a: assert property (events.nvm_write_done |=> r.req_two[4]) // RULE20
		else $error("write done flag not set");
	coll_set_a: assert property (events.bus_collision |=> r.req_two[3]) // RULE20
		else $error("collision flag not set");
	nvm_hold_a: assert property (r.req_two[4] && !wr_req2 |=> r.req_two[4]) // RULE20
		else $error("write done flag dropped");
	lv_set_a: assert property (events.low_voltage |=> r.req_two[2]) // RULE21
		else $error("low voltage flag not set");
	t3_set_a: assert property (events.timer3_ovf |=> r.req_two[1]) // RULE21
		else $error("timer3 flag not set");
	ecc_match_a: assert property (enhanced_mode == ICFR_CC_COMPARE && events.enhanced_match // RULE22
		|=> r.req_two[0] == HAS_ENHANCED) else $error("enhanced flag wrong");
	ecc_pwm_a: assert property (enhanced_mode == ICFR_CC_PWM && !wr_req2 && !r.req_two[0] // RULE22
		|=> !r.req_two[0]) else $error("enhanced flag set in pwm mode");
	low_vec_a: assert property (seq_low_only |=> irq_request && irq_vector == VEC_LOW) // RULE23
		else $error("low priority not at low vector");
endmodule : icfr_flags
`default_nettype wire

// ===== icfr_src.sv
// Event source model: turns a kick from the bench into a one-cycle peripheral pulse.
// Assumes kicks are requested right after a rising edge of clk.
`default_nettype none
module icfr_src (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Kick request
	input wire logic go,
	input wire logic [4:0] sel,
	// Pulses to the block
	output icfr_pkg::icfr_events_t events
);
	import icfr_pkg::*;
	// One pulse per kick, so every kick is counted once
	always_ff @(posedge clk) begin
		if (srst || !go) begin
			events <= '0;
		end else begin
			events <= icfr_events_t'(17'h1 << sel);
		end
	end
endmodule : icfr_src
`default_nettype wire

// ===== tb.sv
// Bench for the interrupt control and flag registers: APB master, event model, expected values.
// Assumes the default variant with every optional source present.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import icfr_pkg::*;
	logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
	logic [7:0] paddr = '0, latch = '0, ra, pull;
	logic [31:0] pwdata = '0, prdata, rdv, d;
	logic pready, pslverr, ev0, irq;
	logic [4:0] sel = '0;
	logic [2:0] pin = '0;
	logic [1:0] cmp = '0;
	logic [23:0] vec;
	icfr_events_t events;
	icfr_ccmode_t mode1 = ICFR_CC_CAPTURE, mode2 = ICFR_CC_CAPTURE;
	icfr_enables_t en = '0;
	int err_count = 0, checks_done = 0, pc;
	int tsel [11] = '{16, 15, 10, 9, 7, 6, 5, 4, 3, 2, 1};
	int tbit [11] = '{128, 64, 8, 4, 2, 1, 16, 8, 4, 2, 1};
	integer seed = 32'h322B1BBF;
	always #25 clk = ~clk;
	icfr_src src (.clk(clk), .srst(srst), .go(go), .sel(sel), .events(events));
	icfr_flags dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
		.capcomp_one_mode(mode1), .enhanced_mode(mode2), .ext_irq_pin(pin), .comparator_out(cmp),
		.portb_latch(latch), .enables(en), .portb_pullup_enable(pull), .ext_irq0_event(ev0),
		.irq_request(irq), .irq_vector(vec));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1);
		rdv = prdata;
		chk(32'(pslverr), 32'(a > OFS_STATUS));
		chk(n, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so the next call never drives psel twice in one step
		@(posedge clk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdv, exp);
	endtask : rd
	task automatic kick(input logic [4:0] s);
		go <= 1'b1;
		sel <= s;
		@(posedge clk);
		go <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : kick
	task automatic pin_set(input int i, input logic v);
		pc = 0;
		pin[i] <= v;
		repeat (4) begin
			@(posedge clk);
			if (ev0 === 1'b1) pc++;
		end
	endtask : pin_set
	// Request level lags the core write by one cycle
	task automatic vec_is(input logic [7:0] core, input logic r, input logic [23:0] v);
		apb(1'b1, OFS_CORE, {24'h0, core});
		repeat (3) @(posedge clk);
		chk({7'h0, irq, vec}, {7'h0, r, v});
	endtask : vec_is
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		latch <= 8'($random(seed));
		@(posedge clk);
		rd(OFS_CTRL2, 32'hE5);
		rd(OFS_CTRL3, 32'hC0);
		rd(OFS_REQ1, 32'h0);
		rd(OFS_REQ2, 32'h0);
		rd(8'h20, 32'h0);
		chk(32'(pull), 32'h0);
		d = $random(seed);
		apb(1'b1, OFS_CTRL2, d);
		rd(OFS_CTRL2, d & 32'hE5);
		apb(1'b1, OFS_CTRL3, 32'hFFFFFFFF);
		rd(OFS_CTRL3, 32'hDB);
		apb(1'b1, OFS_CTRL3, 32'hC0);
		apb(1'b1, OFS_CTRL2, 32'h0);
		repeat (2) @(posedge clk);
		chk(32'(pull), 32'(latch));
		pin_set(0, 1'b1);
		chk(pc, 0);
		pin_set(0, 1'b0);
		chk(pc, 1);
		apb(1'b1, OFS_CTRL2, 32'h40);
		pin_set(0, 1'b1);
		chk(pc, 1);
		pin_set(1, 1'b1);
		rd(OFS_CTRL3, 32'hC0);
		pin_set(1, 1'b0);
		rd(OFS_CTRL3, 32'hC1);
		apb(1'b1, OFS_CTRL3, 32'hC0);
		pin_set(2, 1'b1);
		rd(OFS_CTRL3, 32'hC2);
		apb(1'b1, OFS_CTRL3, 32'hC0);
		for (int k = 0; k < 11; k++) begin
			ra = (k < 6) ? OFS_REQ1 : OFS_REQ2;
			kick(5'(tsel[k]));
			rd(ra, 32'(tbit[k]));
			apb(1'b1, ra, 32'h0);
			rd(ra, 32'h0);
		end
		mode1 <= ICFR_CC_PWM;
		mode2 <= ICFR_CC_PWM;
		kick(9);
		kick(8);
		kick(1);
		kick(0);
		rd(OFS_REQ1, 32'h0);
		rd(OFS_REQ2, 32'h0);
		mode1 <= ICFR_CC_COMPARE;
		mode2 <= ICFR_CC_COMPARE;
		kick(9);
		kick(8);
		kick(0);
		rd(OFS_REQ1, 32'h04);
		rd(OFS_REQ2, 32'h01);
		apb(1'b1, OFS_REQ1, 32'h0);
		apb(1'b1, OFS_REQ2, 32'h0);
		kick(14);
		apb(1'b1, OFS_REQ1, 32'h0);
		rd(OFS_REQ1, 32'h20);
		kick(13);
		rd(OFS_REQ1, 32'h0);
		kick(12);
		apb(1'b1, OFS_REQ1, 32'h0);
		rd(OFS_REQ1, 32'h10);
		kick(11);
		rd(OFS_REQ1, 32'h0);
		cmp <= 2'b01;
		repeat (3) @(posedge clk);
		rd(OFS_REQ2, 32'h40);
		apb(1'b1, OFS_REQ2, 32'h0);
		kick(6);
		fork
			apb(1'b1, OFS_REQ1, 32'h0);
			kick(6);
		join
		rd(OFS_REQ1, 32'h01);
		en.req_one_enable <= 8'h01;
		vec_is(8'h00, 1'b0, VEC_HIGH);
		vec_is(8'h80, 1'b0, VEC_HIGH);
		vec_is(8'hC0, 1'b1, VEC_HIGH);
		vec_is(8'hC1, 1'b1, VEC_LOW);
		en.req_one_priority <= 8'h01;
		vec_is(8'h81, 1'b1, VEC_HIGH);
		apb(1'b1, OFS_REQ1, 32'h0);
		en.req_one_priority <= 8'h00;
		en.timer0_ovf_pending <= 1'b1;
		vec_is(8'hC1, 1'b1, VEC_LOW);
		apb(1'b1, OFS_CTRL2, 32'h44);
		vec_is(8'h81, 1'b1, VEC_HIGH);
		en.timer0_ovf_pending <= 1'b0;
		en.port_change_pending <= 1'b1;
		vec_is(8'hC1, 1'b1, VEC_LOW);
		apb(1'b1, OFS_CTRL2, 32'h41);
		vec_is(8'h81, 1'b1, VEC_HIGH);
		test_done;
	end
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		$display("BAD at %0t: watchdog expired", $time);
		test_done;
	end
endmodule : tb
`default_nettype wire
